//--- common/actmc_pkg.sv
// shared constants, types and helpers of the atm cell mapper
package actmc_pkg;
  // --------------------------------------------------------------------
  // register map and reset values
  // --------------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFS  = 8'h00;
  localparam logic [7:0]  CHAN_OFS  = 8'h04;
  localparam logic [7:0]  STAT_OFS  = 8'h08;
  localparam logic [7:0]  TXDAT_OFS = 8'h0c;
  localparam logic [7:0]  RXDAT_OFS = 8'h10;
  localparam logic [16:0] CTRL_RST  = 17'h0c004;
  localparam logic [31:0] CHAN_RST  = 32'hffff_ffff;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  localparam logic [2:0]  DEPTH_MIN = 3'h2;
  localparam logic [2:0]  DEPTH_MAX = 3'h4;
  // --------------------------------------------------------------------
  // cell and frame geometry, delineation counts, hec and idle cell values
  // --------------------------------------------------------------------
  localparam logic [8:0]  CELL_BYTES = 9'h035;
  localparam logic [8:0]  CELL_BITS  = 9'h1a8;
  localparam logic [8:0]  HDR_BITS   = 9'h028;
  localparam logic [8:0]  T1_FRAME   = 9'h0c1;
  localparam logic [8:0]  E1_FRAME   = 9'h100;
  localparam logic [8:0]  FIFO_SLOTS = 9'h100;
  localparam logic [4:0]  TS16       = 5'h10;
  localparam logic [2:0]  PRESYNC_N  = 3'h6;
  localparam logic [2:0]  SYNC_LOSS  = 3'h7;
  localparam logic [7:0]  HEC_COSET  = 8'h55;
  localparam logic [7:0]  HEC_POLY   = 8'h07;
  localparam logic [31:0] IDLE_HDR   = 32'h0000_0001;
  localparam logic [7:0]  IDLE_FILL  = 8'h6a;

  typedef struct packed {
    logic       framerTs0Passthrough;
    logic       framerTxClockSourceBit;
    logic       framerRxClockSourceBit;
    logic       hecCorrect;
    logic       idleFilter;
    logic       descrambleEn;
    logic       scrambleEn;
    logic       hecInsert;
    logic       txCellControlBitThree;
    logic       txClearChannelSelect;
    logic       rxCellSyncIgnore;
    logic       txCellSyncIgnore;
    logic       rxLineTypeSelect;
    logic       txLineTypeSelect;
    logic [2:0] txDepth;
  } actmc_ctrl_t;

  typedef enum logic [1:0] {
    HUNT    = 2'b00,
    PRESYNC = 2'b01,
    SYNC    = 2'b11
  } actmc_delin_t;

  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ (((c[7] ^ d[i]) == 1'b1) ? HEC_POLY : 8'h00);
    end
    return c ^ HEC_COSET;
  endfunction

  function automatic logic [8:0] bin2gray(input logic [8:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [8:0] gray2bin(input logic [8:0] g);
    logic [8:0] b;
    b = g;
    for (int i = 7; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction
endpackage

//--- hw/actmc_cell_mapper.sv
// atm cell mapper between a register bus and a t1/e1 framer cell stream
// Overview of operation
// R1 - transmit buffer holds up to four cells
// R2 - transmit depth selectable two, three, four cells
// R3 - optional hec insertion and payload scrambling
// R4 - hec delineation, four cell receive buffer
// R5 - optional descrambling, drop idle/unassigned cells
// R6 - correct single-bit header errors
// R7 - full, clear-channel (e1 only), fractional clocking
// R8 - full mode: framer clock bits, sync used
// R9 - sync pulse byte-aligns, locates overhead positions
// R10 - t1 always gaps framing bit
// R11 - e1 tx skips ts0/ts16 unless clear-channel
// R12 - e1 rx with sync skips ts0/ts16
// R13 - rx clear-channel via sync ignore or fractional
// R14 - fractional: clock bits 0, sync ignored
// R15 - gapped clock only in selected timeslots
// R16 - fractional t1 framing bit gapped by framer
// R17 - software deselects e1 ts0/ts16 if wanted
// R18 - line type bit; tx clear needs ts0 passthrough
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// dual clock byte fifo
// ----------------------------------------------------------------------
module actmc_cell_fifo (
  // write side
  input  wire logic       wrClk,
  input  wire logic       wrRst,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  output logic      [8:0] wrFree,
  // read side
  input  wire logic       rdClk,
  input  wire logic       rdRst,
  input  wire logic       rdEn,
  output logic      [7:0] rdData,
  output logic      [8:0] rdCount
);
  logic [7:0] mem [256];
  logic [8:0] wBin;
  logic [8:0] wGray;
  logic [8:0] rgMeta;
  logic [8:0] rgSync;
  logic [8:0] rBin;
  logic [8:0] rGray;
  logic [8:0] wgMeta;
  logic [8:0] wgSync;

  always_ff @(posedge wrClk) begin
    if (wrEn) begin
      mem[wBin[7:0]] <= wrData;
    end
    if (wrRst) begin
      wBin   <= 9'h0;
      wGray  <= 9'h0;
      rgMeta <= 9'h0;
      rgSync <= 9'h0;
    end else begin
      rgMeta <= rGray;
      rgSync <= rgMeta;
      if (wrEn) begin
        wBin  <= wBin + 9'h1;
        wGray <= actmc_pkg::bin2gray(wBin + 9'h1);
      end
    end
  end

  always_ff @(posedge rdClk) begin
    if (rdRst) begin
      rBin   <= 9'h0;
      rGray  <= 9'h0;
      wgMeta <= 9'h0;
      wgSync <= 9'h0;
    end else begin
      wgMeta <= wGray;
      wgSync <= wgMeta;
      if (rdEn) begin
        rBin  <= rBin + 9'h1;
        rGray <= actmc_pkg::bin2gray(rBin + 9'h1);
      end
    end
  end

  assign wrFree  = actmc_pkg::FIFO_SLOTS - (wBin - actmc_pkg::gray2bin(rgSync));
  assign rdCount = actmc_pkg::gray2bin(wgSync) - rBin;
  assign rdData  = mem[rBin[7:0]];
endmodule

// ----------------------------------------------------------------------
// top level
// ----------------------------------------------------------------------
module actmc_cell_mapper (
  // system clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // framer cell stream, all on the framer's line clock
  input  wire logic        lineClk,
  input  wire logic        txFrameSync,
  input  wire logic        rxFrameSync,
  input  wire logic        rxLineData,
  output logic             txLineData,
  // framer control
  output logic             framerRxClockSourceBit,
  output logic             framerTxClockSourceBit,
  output logic             framerTs0Passthrough,
  output logic      [31:0] perChannelSelect
);
  actmc_pkg::actmc_ctrl_t  ctrlReg;
  actmc_pkg::actmc_ctrl_t  cfgMeta;
  actmc_pkg::actmc_ctrl_t  cfgLink;
  actmc_pkg::actmc_delin_t rxState;
  logic [1:0]  delinMeta;
  logic [1:0]  delinSync;
  logic        lineRstMeta;
  logic        lineRst;

  function automatic logic [8:0] nextPos(input logic s, input logic [8:0] p, input logic e1);
    logic [8:0] last;
    last = e1 ? actmc_pkg::E1_FRAME - 9'h1 : actmc_pkg::T1_FRAME - 9'h1;
    return (s || p == last) ? 9'h0 : p + 9'h1;
  endfunction

  // overhead bit positions taken out of the cell stream
  function automatic logic gapSlot(input logic [8:0] p, input logic e1, input logic keep);
    if (!e1) begin
      return p == 9'h0;
    end
    return !keep && (p[7:3] == 5'h0 || p[7:3] == actmc_pkg::TS16);
  endfunction

  // --------------------------------------------------------------------
  // bus slave
  // --------------------------------------------------------------------
  logic [7:0]  dpAddr;
  logic        dpWrite;
  logic [8:0]  txFree;
  logic [8:0]  rxCount;
  logic [7:0]  rxHead;
  logic [31:0] readMux;

  wire logic       addrPhase = hsel && htrans[1] && hready;
  wire logic       mapped    = haddr[31:8] == 24'h0;
  wire logic       rdAccess  = addrPhase && !hwrite && mapped;
  wire logic       rxPop     = rdAccess && haddr[7:0] == actmc_pkg::RXDAT_OFS && rxCount != 9'h0;
  wire logic [8:0] txUsed    = actmc_pkg::FIFO_SLOTS - txFree;
  // out of range depth codes fall back to the nearest legal depth
  wire logic [2:0] depthCells = (ctrlReg.txDepth < actmc_pkg::DEPTH_MIN) ? actmc_pkg::DEPTH_MIN :
                                (ctrlReg.txDepth > actmc_pkg::DEPTH_MAX) ? actmc_pkg::DEPTH_MAX :
                                ctrlReg.txDepth; // [R2]
  wire logic [8:0] txLimit   = {6'h0, depthCells} * actmc_pkg::CELL_BYTES;
  wire logic       txRoom    = txUsed < txLimit; // [R1]
  wire logic       txPush    = dpWrite && dpAddr == actmc_pkg::TXDAT_OFS && txRoom;

  always_comb begin
    readMux = 32'h0;
    if (mapped) begin
      case (haddr[7:0])
        actmc_pkg::CTRL_OFS:  readMux = {15'h0, ctrlReg};
        actmc_pkg::CHAN_OFS:  readMux = perChannelSelect;
        actmc_pkg::STAT_OFS:  readMux = {12'h0, delinSync, txUsed, rxCount};
        actmc_pkg::RXDAT_OFS: readMux = {23'h0, rxCount != 9'h0, rxHead};
        default:              readMux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dpAddr    <= 8'h0;
      dpWrite   <= 1'b0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dpWrite   <= addrPhase && hwrite && mapped && hsize == actmc_pkg::HSIZE_WORD;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addrPhase) begin
        dpAddr <= haddr[7:0];
        hrdata <= readMux;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrlReg          <= actmc_pkg::CTRL_RST;
      perChannelSelect <= actmc_pkg::CHAN_RST;
    end else if (dpWrite && dpAddr == actmc_pkg::CTRL_OFS) begin
      ctrlReg <= hwdata[16:0]; // [R8] [R14] [R18]
    end else if (dpWrite && dpAddr == actmc_pkg::CHAN_OFS) begin
      perChannelSelect <= hwdata; // [R15]
    end
  end

  // the framer acts on these bits; gapping of its clock stays on its side
  assign framerRxClockSourceBit = ctrlReg.framerRxClockSourceBit; // [R8] [R14]
  assign framerTxClockSourceBit = ctrlReg.framerTxClockSourceBit; // [R8] [R14]
  assign framerTs0Passthrough   = ctrlReg.framerTs0Passthrough; // [R18]

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      delinMeta <= 2'h0;
      delinSync <= 2'h0;
    end else begin
      delinMeta <= rxState;
      delinSync <= delinMeta;
    end
  end

  // --------------------------------------------------------------------
  // line domain reset and configuration crossing
  // --------------------------------------------------------------------
  // config is quasi static; software changes it only while the link idles
  always_ff @(posedge lineClk) begin
    lineRstMeta <= srst;
    lineRst     <= lineRstMeta;
    cfgMeta     <= ctrlReg;
    cfgLink     <= cfgMeta;
  end

  // --------------------------------------------------------------------
  // transmit path
  // --------------------------------------------------------------------
  logic [8:0]  txPos;
  logic [2:0]  txBitIdx;
  logic [5:0]  txCellIdx;
  logic        txDataCell;
  logic        txPayByte;
  logic [7:0]  txShift;
  logic [31:0] txHdr;
  logic [42:0] txScr;
  logic [7:0]  txHead;
  logic [8:0]  txCount;

  wire logic       txUseSync = !cfgLink.txCellSyncIgnore; // [R8] [R14]
  wire logic       txKeep    = cfgLink.txClearChannelSelect && cfgLink.txLineTypeSelect; // [R7]
  wire logic [8:0] txPosNow  = nextPos(txFrameSync, txPos, cfgLink.txLineTypeSelect); // [R18]
  // in gapped mode every clock edge is cell payload [R16] [R17]
  wire logic       txPayload = !(txUseSync && gapSlot(txPosNow, cfgLink.txLineTypeSelect,
                                                      txKeep)); // [R10] [R11]
  wire logic [2:0] txIdxNow  = (txUseSync && txFrameSync) ? 3'h0 : txBitIdx; // [R9]
  wire logic       loadByte  = txPayload && txIdxNow == 3'h0;
  wire logic       dataNow   = (txCellIdx == 6'h0) ? txCount >= actmc_pkg::CELL_BYTES : txDataCell;
  wire logic       hdrByte   = txCellIdx < 6'h4;
  wire logic       hecByte   = txCellIdx == 6'h4;
  wire logic [31:0] idleSh   = actmc_pkg::IDLE_HDR << {txCellIdx[1:0], 3'h0};
  wire logic [7:0] idleByte  = hdrByte ? idleSh[31:24] : actmc_pkg::IDLE_FILL;
  // idle cells always get a valid hec
  wire logic [7:0] newByte   = (hecByte && (cfgLink.hecInsert || !dataNow)) ?
                               actmc_pkg::crc8(txHdr) : (dataNow ? txHead : idleByte); // [R3]
  wire logic       txPop     = loadByte && dataNow; // [R1]
  wire logic       rawBit    = loadByte ? newByte[7] : txShift[7];
  wire logic       payBit    = loadByte ? txCellIdx > 6'h4 : txPayByte;
  wire logic       scrBit    = payBit && cfgLink.scrambleEn;
  wire logic       outBit    = scrBit ? rawBit ^ txScr[42] : rawBit; // [R3]

  always_ff @(posedge lineClk) begin
    if (lineRst) begin
      txPos      <= 9'h0;
      txBitIdx   <= 3'h0;
      txCellIdx  <= 6'h0;
      txDataCell <= 1'b0;
      txPayByte  <= 1'b0;
      txShift    <= 8'h0;
      txHdr      <= 32'h0;
      txScr      <= 43'h0;
      txLineData <= 1'b1;
    end else begin
      txPos    <= txPosNow;
      txBitIdx <= txPayload ? txIdxNow + 3'h1 : txIdxNow;
      if (!txPayload) begin
        txLineData <= 1'b1;
      end else begin
        txLineData <= outBit;
        if (scrBit) begin
          txScr <= {txScr[41:0], outBit};
        end
        if (loadByte) begin
          txShift    <= {newByte[6:0], 1'b0};
          txPayByte  <= payBit;
          txDataCell <= dataNow;
          txCellIdx  <= (txCellIdx == 6'(actmc_pkg::CELL_BYTES - 9'h1)) ? 6'h0 :
                        txCellIdx + 6'h1;
          if (hdrByte) begin
            txHdr <= {txHdr[23:0], newByte};
          end
        end else begin
          txShift <= {txShift[6:0], 1'b0};
        end
      end
    end
  end

  actmc_cell_fifo txFifo (
    .wrClk   (ref_clk),
    .wrRst   (srst),
    .wrEn    (txPush),
    .wrData  (hwdata[7:0]),
    .wrFree  (txFree),
    .rdClk   (lineClk),
    .rdRst   (lineRst),
    .rdEn    (txPop),
    .rdData  (txHead),
    .rdCount (txCount)
  );

  // --------------------------------------------------------------------
  // receive path
  // --------------------------------------------------------------------
  logic [8:0]  rxPos;
  logic [39:0] rxWin;
  logic [8:0]  rxCellBit;
  logic [2:0]  rxCnt;
  logic [42:0] rxDs;
  logic [7:0]  rxByte;
  logic [39:0] rxHdr;
  logic        rxAccept;
  logic [8:0]  rxFree;
  logic [31:0] fixHdr;
  logic        fixOk;

  localparam logic [2:0] PRESYNC_LAST = actmc_pkg::PRESYNC_N - 3'h1;
  localparam logic [2:0] SYNC_LAST    = actmc_pkg::SYNC_LOSS - 3'h1;

  wire logic        rxUseSync = !cfgLink.rxCellSyncIgnore; // [R13]
  wire logic [8:0]  rxPosNow  = nextPos(rxFrameSync, rxPos, cfgLink.rxLineTypeSelect);
  wire logic        rxPayload = !(rxUseSync && gapSlot(rxPosNow, cfgLink.rxLineTypeSelect,
                                                       1'b0)); // [R10] [R12]
  wire logic [39:0] newWin    = {rxWin[38:0], rxLineData};
  wire logic        hecOk     = actmc_pkg::crc8(newWin[39:8]) == newWin[7:0]; // [R4]
  wire logic        inSync    = rxState == actmc_pkg::SYNC;
  wire logic        rxPayBit  = inSync && rxCellBit >= actmc_pkg::HDR_BITS;
  wire logic        dsBit     = rxPayBit && cfgLink.descrambleEn;
  wire logic        dBit      = dsBit ? rxLineData ^ rxDs[42] : rxLineData; // [R5]
  wire logic        hdrEnd    = rxState != actmc_pkg::HUNT &&
                                rxCellBit == actmc_pkg::HDR_BITS - 9'h1;
  wire logic        idleHdr   = cfgLink.idleFilter && fixHdr[31:4] == 28'h0; // [R5]
  wire logic [8:0]  hdrK      = rxCellBit - actmc_pkg::HDR_BITS;
  wire logic [39:0] hdrSh     = rxHdr << {hdrK[2:0], 3'h0};
  wire logic        hdrWr     = rxCellBit >= actmc_pkg::HDR_BITS && hdrK < 9'h5;
  wire logic        payWr     = rxCellBit > actmc_pkg::HDR_BITS && rxCellBit[2:0] == 3'h7;
  wire logic        rxWe      = rxPayload && inSync && rxAccept && (hdrWr || payWr);
  wire logic [7:0]  rxWrData  = hdrWr ? hdrSh[39:32] : {rxByte[6:0], dBit};

  // header repair: a one-bit syndrome, a single error in the hec octet, leaves the header good
  always_comb begin
    fixHdr = newWin[39:8];
    fixOk  = hecOk;
    if (!hecOk && cfgLink.hecCorrect) begin
      if ($countones(actmc_pkg::crc8(newWin[39:8]) ^ newWin[7:0]) == 1) begin
        fixOk = 1'b1;
      end
      for (int i = 0; i < 32; i++) begin
        if (actmc_pkg::crc8(newWin[39:8] ^ (32'h1 << i)) == newWin[7:0]) begin
          fixHdr = newWin[39:8] ^ (32'h1 << i); // [R6]
          fixOk  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge lineClk) begin
    if (lineRst) begin
      rxPos     <= 9'h0;
      rxWin     <= 40'h0;
      rxState   <= actmc_pkg::HUNT;
      rxCellBit <= 9'h0;
      rxCnt     <= 3'h0;
      rxDs      <= 43'h0;
      rxByte    <= 8'h0;
      rxHdr     <= 40'h0;
      rxAccept  <= 1'b0;
    end else begin
      rxPos <= rxPosNow;
      if (rxPayload) begin
        rxWin     <= newWin;
        rxByte    <= {rxByte[6:0], dBit};
        rxCellBit <= (rxCellBit == actmc_pkg::CELL_BITS - 9'h1) ? 9'h0 : rxCellBit + 9'h1;
        if (dsBit) begin
          rxDs <= {rxDs[41:0], rxLineData};
        end
        case (rxState)
          actmc_pkg::HUNT: begin
            if (hecOk) begin
              rxState   <= actmc_pkg::PRESYNC; // [R4]
              rxCellBit <= actmc_pkg::HDR_BITS;
              rxCnt     <= 3'h0;
            end
          end
          actmc_pkg::PRESYNC: begin
            if (hdrEnd && !hecOk) begin
              rxState <= actmc_pkg::HUNT;
            end else if (hdrEnd && rxCnt == PRESYNC_LAST) begin
              rxState <= actmc_pkg::SYNC;
              rxCnt   <= 3'h0;
            end else if (hdrEnd) begin
              rxCnt <= rxCnt + 3'h1;
            end
          end
          actmc_pkg::SYNC: begin
            if (hdrEnd) begin
              rxHdr    <= {fixHdr, newWin[7:0]};
              rxAccept <= fixOk && !idleHdr && rxFree >= actmc_pkg::CELL_BYTES; // [R4] [R5]
              if (fixOk) begin
                rxCnt <= 3'h0;
              end else if (rxCnt == SYNC_LAST) begin
                rxState <= actmc_pkg::HUNT;
              end else begin
                rxCnt <= rxCnt + 3'h1;
              end
            end
          end
          default: begin
            rxState <= actmc_pkg::HUNT;
          end
        endcase
      end
    end
  end

  actmc_cell_fifo rxFifo (
    .wrClk   (lineClk),
    .wrRst   (lineRst),
    .wrEn    (rxWe),
    .wrData  (rxWrData),
    .wrFree  (rxFree),
    .rdClk   (ref_clk),
    .rdRst   (srst),
    .rdEn    (rxPop),
    .rdData  (rxHead),
    .rdCount (rxCount)
  );
endmodule

//--- dv/actmc_cell_mapper_assertions.sv
// port assertions of the atm cell mapper
`timescale 1ns/1ns
module actmc_cell_mapper_assertions (
  // system
  input wire logic        ref_clk,
  input wire logic        srst,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // framer control
  input wire logic        framerRxClockSourceBit,
  input wire logic        framerTxClockSourceBit,
  input wire logic        framerTs0Passthrough,
  input wire logic [31:0] perChannelSelect
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ------
  // data phase flags
  // ------
  logic wrCtrl;
  logic wrChan;
  logic rdCtrl;
  logic rdChan;
  logic rdRx;
  wire  acc   = hsel & htrans[1] & hready;
  wire  wr    = acc & hwrite & (hsize == actmc_pkg::HSIZE_WORD);
  wire  rd    = acc & !hwrite;
  wire  ctrlA = (haddr == {24'h0, actmc_pkg::CTRL_OFS});
  wire  chanA = (haddr == {24'h0, actmc_pkg::CHAN_OFS});
  wire  rxA   = (haddr == {24'h0, actmc_pkg::RXDAT_OFS});
  always_ff @(posedge ref_clk) begin
    wrCtrl <= wr & ctrlA;
    wrChan <= wr & chanA;
    rdCtrl <= rd & ctrlA;
    rdChan <= rd & chanA;
    rdRx   <= rd & rxA;
  end
  // ------
  // properties
  // ------
  property p_ready;
    hreadyout && !hresp;
  endproperty
  a_ready: assert property (p_ready) else $error("bus stalled or errored");
  property p_clk_src;
    $changed({framerTxClockSourceBit, framerRxClockSourceBit}) |-> $past(wrCtrl);
  endproperty
  a_clk_src: assert property (p_clk_src) else $error("clock bits moved alone");
  property p_ts0;
    $changed(framerTs0Passthrough) |-> $past(wrCtrl);
  endproperty
  a_ts0: assert property (p_ts0) else $error("passthrough moved alone");
  property p_chan_wr;
    wrChan |=> perChannelSelect == $past(hwdata);
  endproperty
  a_chan_wr: assert property (p_chan_wr) else $error("channel select not written");
  property p_chan_hold;
    $changed(perChannelSelect) |-> $past(wrChan);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel select moved");
  property p_ctrl_rd;
    rdCtrl && !$past(wrCtrl) |->
      hrdata[16:14] == {framerTs0Passthrough, framerTxClockSourceBit, framerRxClockSourceBit};
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback differs");
  property p_chan_rd;
    rdChan && !$past(wrChan) |-> hrdata == perChannelSelect;
  endproperty
  a_chan_rd: assert property (p_chan_rd) else $error("channel readback differs");
  property p_rx_rd;
    rdRx |-> hrdata[31:9] == 23'h0;
  endproperty
  a_rx_rd: assert property (p_rx_rd) else $error("rx word has stray bits");
  property p_stand;
    !acc |=> $stable(hrdata);
  endproperty
  a_stand: assert property (p_stand) else $error("read data moved when idle");
  c_ctrl: cover property (wrCtrl);
  c_chan: cover property (wrChan);
  c_rx: cover property (rdRx && hrdata[8]);
endmodule

//--- dv/actmc_framer_model.sv
// framer side: frame sync on the bench's line clock, line looped back
`timescale 1ns/1ns
module actmc_framer_model (
  // line side
  input  wire logic lineClk,
  input  wire logic txLineData,
  output logic      txFrameSync,
  output logic      rxFrameSync,
  output logic      rxLineData
);
  logic [8:0] pos = 9'h000;
  logic       syncDly = 1'b0;
  initial begin
    txFrameSync = 1'b0;
    rxFrameSync = 1'b0;
    rxLineData  = 1'b1;
  end
  // one sync per e1 frame; the clock stands when the bench stops it
  always @(posedge lineClk) begin
    pos         <= (pos == actmc_pkg::E1_FRAME - 9'h001) ? 9'h000 : pos + 9'h001;
    txFrameSync <= (pos == actmc_pkg::E1_FRAME - 9'h001);
    // looped data trails tx by two edges, so the rx sync does too
    syncDly     <= txFrameSync;
    rxFrameSync <= syncDly;
    rxLineData  <= txLineData;
  end
endmodule

//--- dv/test_atm_cell_tdm_mapper_clocking.sv
// self-checking testbench of the atm cell mapper
`timescale 1ns/1ns
module test_atm_cell_tdm_mapper_clocking;
  logic        ref_clk = 1'b0;
  logic        srst    = 1'b1;
  logic        hsel    = 1'b1;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = actmc_pkg::HSIZE_WORD;
  logic [31:0] hwdata  = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic [31:0] perChannelSelect;
  logic        hreadyout, hresp, lineClk, txFrameSync, rxFrameSync, rxLineData, txLineData;
  logic        framerRxClockSourceBit, framerTxClockSourceBit, framerTs0Passthrough;
  logic        linkRun = 1'b1;
  int          failures = 0;
  int          compares = 0;
  // e1 both ways, tx clear channel, rx sync ignored, hec/scramble/filter on, depth 0
  localparam logic [31:0] CFG = 32'h0001_ded8;
  assign hready = hreadyout;
  always #4 ref_clk = ~ref_clk;
  initial begin
    lineClk = 1'b0;
    #3;
    forever #6 if (linkRun) lineClk = ~lineClk;
  end
  actmc_cell_mapper i_actmc_cell_mapper (.ref_clk, .srst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .lineClk, .txFrameSync,
    .rxFrameSync, .rxLineData, .txLineData, .framerRxClockSourceBit, .framerTxClockSourceBit,
    .framerTs0Passthrough, .perChannelSelect);
  actmc_framer_model i_actmc_framer_model (.lineClk, .txLineData, .txFrameSync, .rxFrameSync,
    .rxLineData);
  // ------
  // helpers
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge ref_clk);
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // own header check code, bit serial, generator x^8+x^2+x+1 with coset
  function automatic logic [7:0] hec_of(input logic [31:0] h);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 31; i >= 0; i--) r = {r[6:0], 1'b0} ^ ((r[7] ^ h[i]) ? 8'h07 : 8'h00);
    return r ^ 8'h55;
  endfunction
  function automatic logic [7:0] cell_byte(input int k, input int j);
    logic [31:0] h;
    h = 32'h0000_0100 | k;
    if (j < 4) return h[31-8*j -: 8];
    if (j == 4) return hec_of(h);
    return 8'(j * 3 + k);
  endfunction
  // ------
  // scenarios
  // ------
  task automatic test_regs;
    logic [31:0] r;
    bus(1'b0, actmc_pkg::CTRL_OFS, 32'h0, r);
    check(r, {15'h0, actmc_pkg::CTRL_RST});
    check({29'h0, framerTs0Passthrough, framerTxClockSourceBit, framerRxClockSourceBit},
          32'h3);
    bus(1'b0, actmc_pkg::CHAN_OFS, 32'h0, r);
    check(r, actmc_pkg::CHAN_RST);
    bus(1'b0, 8'h20, 32'h0, r);
    check(r, 32'h0);
    // software keeps ts0 and ts16 out of the gapped clock itself
    bus(1'b1, actmc_pkg::CHAN_OFS, 32'hfffe_fffe, r);
    @(negedge ref_clk);
    check(perChannelSelect, 32'hfffe_fffe);
    $display("test_regs done");
  endtask
  task automatic test_sync;
    logic [31:0] r;
    int          n;
    bus(1'b1, actmc_pkg::CTRL_OFS, CFG, r);
    @(negedge ref_clk);
    check({31'h0, framerTs0Passthrough}, 32'h1);
    n = 0;
    do begin
      bus(1'b0, actmc_pkg::STAT_OFS, 32'h0, r);
      n++;
    end while (r[19:18] !== 2'b11 && n < 10000);
    check({30'h0, r[19:18]}, 32'h3);
    $display("test_sync done");
  endtask
  // link frozen while writing, so the fill level is exact; overflow writes are lost
  task automatic test_depth(input logic [31:0] ctrl, input int nCells, input int expCells);
    logic [31:0] r;
    int          n;
    bus(1'b1, actmc_pkg::CTRL_OFS, ctrl, r);
    linkRun = 1'b0;
    for (int k = 0; k < nCells; k++) begin
      for (int j = 0; j < 53; j++) begin
        bus(1'b1, actmc_pkg::TXDAT_OFS, {24'h0, (j == 4) ? 8'h00 : cell_byte(k, j)}, r);
      end
    end
    repeat (8) @(posedge ref_clk);
    bus(1'b0, actmc_pkg::STAT_OFS, 32'h0, r);
    check({23'h0, r[17:9]}, expCells * 53);
    linkRun = 1'b1;
    n = 0;
    do begin
      bus(1'b0, actmc_pkg::STAT_OFS, 32'h0, r);
      n++;
    end while (r[8:0] < 9'(expCells * 53) && n < 20000);
    for (int k = 0; k < expCells; k++) begin
      for (int j = 0; j < 53; j++) begin
        bus(1'b0, actmc_pkg::RXDAT_OFS, 32'h0, r);
        check(r, {23'h1, cell_byte(k, j)});
      end
    end
    bus(1'b0, actmc_pkg::RXDAT_OFS, 32'h0, r);
    check({31'h0, r[8]}, 32'h0);
    $display("test_depth done");
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    finish_test();
  end
  initial begin
    // held past three rising link clock edges as well
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    test_regs();
    test_sync();
    test_depth(CFG, 3, 2);
    test_depth(CFG | 32'h7, 5, 4);
    finish_test();
  end
endmodule
bind actmc_cell_mapper actmc_cell_mapper_assertions i_actmc_cell_mapper_assertions (.ref_clk,
  .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .framerRxClockSourceBit, .framerTxClockSourceBit, .framerTs0Passthrough, .perChannelSelect);
